// [verilog/masc_step_cfg.sv]
module masc_step_cfg
  import masc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [1:0]  step_include_bit,
  output logic      [5:0]  step_gain_x,
  output logic      [1:0]  step_neg_is_input_seven,
  output logic      [1:0]  step_neg_auto,
  output logic      [1:0]  step_pos_is_external,
  output logic      [7:0]  step_pos_input_sel,
  output logic      [1:0]  step_skip
);

  // Bus answer state
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pready_q;
  logic        pready_d;
  logic        pslverr_q;
  logic        pslverr_d;

  // Address decode and write qualifiers
  logic [1:0]  hit;
  logic [1:0]  wr_en;
  logic        setup;
  logic        access_wr;
  logic [15:0] rd_word;
  logic [15:0] cfg_view [MASC_NSTEP];

  assign hit[0]    = (paddr == MASC_STEP11_ADDR);
  assign hit[1]    = (paddr == MASC_STEP12_ADDR);
  assign setup     = psel && !penable;
  assign access_wr = psel && penable && pwrite && pready_q;
  assign wr_en     = access_wr ? hit : 2'b00;

  // Read word of the addressed step
  always_comb begin
    rd_word = 16'h0000;
    if (hit[0]) begin
      rd_word = cfg_view[0] & MASC_WRITE_MASK;
    end else if (hit[1]) begin
      rd_word = cfg_view[1] & MASC_WRITE_MASK;
    end
  end

  // One answer per setup cycle, no wait states
  always_comb begin
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    if (setup) begin
      pready_d  = 1'b1;
      pslverr_d = (hit == 2'b00);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (clk_en) begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Read data is loaded at setup and kept afterwards
  always_comb begin
    prdata_d = prdata_q;
    if (setup) begin
      if (pwrite) begin
        prdata_d = 32'h0000_0000;
      end else begin
        prdata_d = {16'h0000, rd_word};
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      prdata_q <= prdata_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // Per step: stored fields, then decode one cycle later
  for (genvar i = 0; i < MASC_NSTEP; i++) begin : g_step
    localparam logic [15:0] RST_CFG   = (i == 0) ? MASC_STEP11_RST : MASC_STEP12_RST;
    localparam logic        RST_INCL  = RST_CFG[MASC_INCL_BIT];
    localparam logic [1:0]  RST_GCODE = RST_CFG[MASC_GAIN_HI:MASC_GAIN_LO];
    localparam logic        RST_NEG   = RST_CFG[MASC_NEG_BIT];
    localparam logic [3:0]  RST_POS   = RST_CFG[MASC_POS_HI:MASC_POS_LO];
    localparam logic        RST_EXT   = !RST_POS[MASC_POS_HI];
    localparam logic        RST_NEG7  = RST_NEG && RST_EXT;
    localparam logic [2:0]  RST_GAIN  = (RST_GCODE == 2'b00) ? MASC_GAIN_X1 :
                                        (RST_GCODE == 2'b01) ? MASC_GAIN_X2 : MASC_GAIN_X4;

    logic        we_hi;
    logic        we_lo;
    logic        en_fld_q;
    logic        en_fld_d;
    logic [1:0]  gcode_q;
    logic [1:0]  gcode_d;
    logic        negsel_q;
    logic        negsel_d;
    logic [3:0]  pcode_q;
    logic [3:0]  pcode_d;
    logic        incl_q;
    logic        incl_d;
    logic        skip_q;
    logic        skip_d;
    logic [2:0]  gain_q;
    logic [2:0]  gain_d;
    logic        negsev_q;
    logic        negsev_d;
    logic        negauto_q;
    logic        negauto_d;
    logic        posext_q;
    logic        posext_d;
    logic [3:0]  possel_q;
    logic [3:0]  possel_d;

    // Byte strobes gate the two halves of a write
    assign we_hi = wr_en[i] && pstrb[1];
    assign we_lo = wr_en[i] && pstrb[0];

    // Include and gain live in the upper byte
    always_comb begin
      en_fld_d = en_fld_q;
      gcode_d  = gcode_q;
      if (we_hi) begin
        en_fld_d = pwdata[MASC_INCL_BIT];
        gcode_d  = pwdata[MASC_GAIN_HI:MASC_GAIN_LO];
      end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        en_fld_q <= RST_INCL;
        gcode_q  <= RST_GCODE;
      end else if (clk_en) begin
        en_fld_q <= en_fld_d;
        gcode_q  <= gcode_d;
      end
    end

    // Input selects live in the lower byte
    always_comb begin
      negsel_d = negsel_q;
      pcode_d  = pcode_q;
      if (we_lo) begin
        negsel_d = pwdata[MASC_NEG_BIT];
        pcode_d  = pwdata[MASC_POS_HI:MASC_POS_LO];
      end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        negsel_q <= RST_NEG;
        pcode_q  <= RST_POS;
      end else if (clk_en) begin
        negsel_q <= negsel_d;
        pcode_q  <= pcode_d;
      end
    end

    // Reserved bits are not stored and read as zero
    assign cfg_view[i] = {en_fld_q, gcode_q, 8'h00, negsel_q, pcode_q};

    // Include decode
    always_comb begin
      incl_d = en_fld_q;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        incl_q <= RST_INCL;
      end else if (clk_en) begin
        incl_q <= incl_d;
      end
    end

    // Skip flag for the sequencer
    always_comb begin
      skip_d = !en_fld_q;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        skip_q <= !RST_INCL;
      end else if (clk_en) begin
        skip_q <= skip_d;
      end
    end

    // Gain decode
    always_comb begin
      gain_d = MASC_GAIN_X1;
      unique case (gcode_q)
        2'b00: begin
          gain_d = MASC_GAIN_X1;
        end
        2'b01: begin
          gain_d = MASC_GAIN_X2;
        end
        2'b10, 2'b11: begin
          gain_d = MASC_GAIN_X4;
        end
      endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        gain_q <= RST_GAIN;
      end else if (clk_en) begin
        gain_q <= gain_d;
      end
    end

    // Internal sources pick the negative input themselves
    always_comb begin
      negauto_d = pcode_q[MASC_POS_HI];
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        negauto_q <= !RST_EXT;
      end else if (clk_en) begin
        negauto_q <= negauto_d;
      end
    end

    // Negative select only counts for external sources
    always_comb begin
      negsev_d = negsel_q && !pcode_q[MASC_POS_HI];
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        negsev_q <= RST_NEG7;
      end else if (clk_en) begin
        negsev_q <= negsev_d;
      end
    end

    // Positive source class
    always_comb begin
      posext_d = !pcode_q[MASC_POS_HI];
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        posext_q <= RST_EXT;
      end else if (clk_en) begin
        posext_q <= posext_d;
      end
    end

    // Raw positive code
    always_comb begin
      possel_d = pcode_q;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        possel_q <= RST_POS;
      end else if (clk_en) begin
        possel_q <= possel_d;
      end
    end

    assign step_include_bit[i]          = incl_q;
    assign step_skip[i]                 = skip_q;
    assign step_gain_x[3*i +: 3]        = gain_q;
    assign step_neg_is_input_seven[i]   = negsev_q;
    assign step_neg_auto[i]             = negauto_q;
    assign step_pos_is_external[i]      = posext_q;
    assign step_pos_input_sel[4*i +: 4] = possel_q;
  end

endmodule

// [verilog/masc_pkg.sv]
package masc_pkg;
  localparam logic [7:0]  MASC_STEP11_IDX   = 8'hDB;
  localparam logic [7:0]  MASC_STEP12_IDX   = 8'hDC;
  localparam logic [11:0] MASC_STEP11_ADDR  = {2'b00, MASC_STEP11_IDX, 2'b00};
  localparam logic [11:0] MASC_STEP12_ADDR  = {2'b00, MASC_STEP12_IDX, 2'b00};
  localparam logic [15:0] MASC_STEP11_RST   = 16'h000B;
  localparam logic [15:0] MASC_STEP12_RST   = 16'h000C;
  localparam int          MASC_INCL_BIT     = 15;
  localparam int          MASC_GAIN_HI      = 14;
  localparam int          MASC_GAIN_LO      = 13;
  localparam int          MASC_NEG_BIT      = 4;
  localparam int          MASC_POS_HI       = 3;
  localparam int          MASC_POS_LO       = 0;
  localparam logic [15:0] MASC_WRITE_MASK   = 16'hE01F;
  localparam logic [3:0]  MASC_POS_TEMP     = 4'h8;
  localparam logic [3:0]  MASC_POS_SHORT    = 4'h9;
  localparam logic [2:0]  MASC_GAIN_X1      = 3'h1;
  localparam logic [2:0]  MASC_GAIN_X2      = 3'h2;
  localparam logic [2:0]  MASC_GAIN_X4      = 3'h4;
  localparam int          MASC_NSTEP        = 2;
endpackage

// [bench/masc_step_cfg_properties.sv]
module masc_step_cfg_chk
  import masc_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [3:0]  pstrb,
  input wire logic [1:0]  step_include_bit,
  input wire logic [1:0]  step_neg_is_input_seven,
  input wire logic [1:0]  step_neg_auto,
  input wire logic [1:0]  step_pos_is_external,
  input wire logic [1:0]  step_skip,
  input wire logic [5:0]  step_gain_x,
  input wire logic [7:0]  step_pos_input_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  property p_skip; step_skip == ~step_include_bit; endproperty
  a_skip: assert property (p_skip) else $error("skip flag wrong");
  property p_rsv; pready && !pwrite |-> prdata[12:5] == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_ext;
    step_pos_is_external == ~{step_pos_input_sel[7], step_pos_input_sel[3]};
  endproperty
  a_ext: assert property (p_ext) else $error("external flag wrong");
  property p_auto; step_neg_auto == ~step_pos_is_external; endproperty
  a_auto: assert property (p_auto) else $error("auto negative wrong");
  property p_neg7; (step_neg_is_input_seven & step_neg_auto) == 2'b00; endproperty
  a_neg7: assert property (p_neg7) else $error("negative not masked");
  property p_gain; step_gain_x[2:0] inside {3'h1, 3'h2, 3'h4}; endproperty
  a_gain: assert property (p_gain) else $error("gain code illegal");
  property p_rdy;
    psel && !penable && clk_en && paddr == MASC_STEP12_ADDR |=> pready && !pslverr;
  endproperty
  a_rdy: assert property (p_rdy) else $error("step 12 not answered");
  property p_incl;
    pready && penable && pwrite && pstrb[1] && paddr == MASC_STEP11_ADDR
      |-> ##2 step_include_bit[0] == $past(pwdata[15], 2);
  endproperty
  a_incl: assert property (p_incl) else $error("include bit wrong");
  c_err: cover property (pready && pslverr);
  c_on: cover property (step_include_bit[0]);
  c_auto: cover property (!step_neg_auto[0]);
endmodule

bind masc_step_cfg masc_step_cfg_chk chk (.*);

// [bench/masc_step_cfg_test.sv]
module masc_step_cfg_test;
  import masc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, arst_n = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, rdy, err, e;
  logic [11:0] paddr = 0;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] pwdata = 0, prdata, r;
  logic [1:0]  incl, n7, na, ext, skip;
  logic [5:0]  gx;
  logic [7:0]  ps;
  int          fails = 0, samples_checked = 0;
  always #2.5 clk = ~clk;
  masc_step_cfg dut (.core_clk(clk), .arst_n, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready(rdy), .pslverr(err), .step_include_bit(incl),
    .step_gain_x(gx), .step_neg_is_input_seven(n7), .step_neg_auto(na),
    .step_pos_is_external(ext), .step_pos_input_sel(ps), .step_skip(skip));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk); psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk); penable <= 1;
    do @(posedge clk); while (rdy !== 1'b1);
    r = prdata; e = err; psel <= 0; penable <= 0;
  endtask
  task automatic wr(input logic [31:0] d);
    apb(1, MASC_STEP11_ADDR, d);
    repeat (3) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, s, x);
    end
  endtask
  task automatic print_verdict;
    $display("checked %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk); arst_n <= 1;
    apb(0, MASC_STEP11_ADDR, 0); chk(r, 32'h0000_000B);
    chk(e, 0);
    apb(0, MASC_STEP12_ADDR, 0); chk(r, 32'h0000_000C); chk(e, 0);
    chk({gx[5:3], ps[7:4], n7[1], na[1], ext[1]}, {3'h1, 4'hC, 3'b010});
    apb(1, MASC_STEP12_ADDR, 32'h0000_6017); repeat (3) @(posedge clk);
    chk({gx[5:3], ps[7:4], n7[1], na[1], ext[1]}, {3'h4, 4'h7, 3'b101});
    apb(0, MASC_STEP12_ADDR, 0); chk(r, 32'h0000_6017);
    wr(32'hFFFF_FFFF); apb(0, MASC_STEP11_ADDR, 0); chk(r, 32'h0000_E01F);
    chk({skip, incl}, 4'b1001);
    $display("reset and access test ended");
    for (int g = 0; g < 4; g++) begin
      wr(32'(g << 13)); chk(gx[2:0], (g < 2) ? g + 1 : 4);
    end
    for (int c = 0; c < 16; c++) begin
      wr(32'h0000_0010 | c);
      chk({n7[0], na[0], ext[0], ps[3:0]}, {c < 8, c > 7, c < 8, 4'(c)});
    end
    $display("field test ended");
    pstrb <= 4'h2; wr(32'h0000_8000); pstrb <= 4'hF;
    apb(0, MASC_STEP11_ADDR, 0); chk(r, 32'h0000_801F);
    apb(0, 12'h000, 0); chk(e, 1); chk(r, 0);
    $display("strobe and unmapped test ended");
    @(posedge clk);
    clk_en <= 0; psel <= 1; pwrite <= 1; paddr <= MASC_STEP11_ADDR; pwdata <= 0;
    repeat (4) @(posedge clk); chk(rdy, 0);
    psel <= 0; clk_en <= 1;
    apb(0, MASC_STEP11_ADDR, 0); chk(r, 32'h0000_801F);
    arst_n <= 0; repeat (3) @(posedge clk); arst_n <= 1;
    apb(0, MASC_STEP11_ADDR, 0); chk(r, 32'h0000_000B);
    chk({skip, incl}, 4'b1100);
    $display("freeze and reset test ended");
    print_verdict;
  end
  initial begin
    #50us; fails++; print_verdict;
  end
endmodule
